// *** companion_supervisor.sv ***
// processor companion supervisor with apb register access
// Behaviour
// - reset output asserts while supply is below programmed trip point
// - after supply recovers, reset stays asserted 100 ms more
// - watchdog timeout programmable from 100 ms to 3 s
// - enabled watchdog not restarted in time pulses reset 100 ms
// - flag records whether undervoltage or watchdog caused last reset
// - active-low reset output driven by supply monitor or watchdog
// - manual reset request is filtered and debounced before acceptance
// - early fail input compared to 1.2 V reference drives fail output
// - two independent 16-bit battery-backed event counters
// - each counter counts rising or falling edges by chosen polarity
// - 64-bit serial number; after lock, writes leave it unchanged
// - reset pin is open drain and also takes manual reset input
// - each counter adds one per detected edge of chosen polarity
`timescale 1ns/100ps
`include "supervisor_consts.svh"
module companion_supervisor #(
  parameter int unsigned HOLD_CYCLES = (`RST_HOLD_MS * (`CLK_HZ / 1000)),
  parameter int unsigned STEP_CYCLES = (`WDT_STEP_MS * (`CLK_HZ / 1000))
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [7:0]  supply_level,
  input  wire logic [7:0]  early_fail_in,
  input  wire logic        event_in_a,
  input  wire logic        event_in_b,
  input  wire logic        sys_rst_in,
  output logic             sys_rst_out,
  output logic             sys_rst_oe,
  output logic             cal_or_fail_out,
  output logic             irq
);
  // =======================================
  // declarations
  localparam int DEB_N = `DEB_CYCLES;

  supervisor_pkg::rst_state_t state_r;
  supervisor_pkg::rst_src_t   src_r;
  supervisor_pkg::cnt_view_t  view_a;
  supervisor_pkg::cnt_view_t  view_b;
  logic [3:0]  ctrl_r;
  logic [7:0]  trip_r;
  logic [4:0]  wdt_steps_r;
  logic [31:0] hold_cnt_r;
  logic [31:0] step_cnt_r;
  logic [4:0]  wdt_cnt_r;
  logic [63:0] serial_r;
  logic [5:0]  irq_stat_r;
  logic [5:0]  irq_en_r;
  logic [5:0]  ev;
  logic        man_s1_r;
  logic        man_s2_r;
  logic [15:0] deb_cnt_r;
  logic        man_req_r;
  logic        man_req_d_r;
  logic        low_v;
  logic        low_v_d_r;
  logic        fail_d_r;
  logic        wdt_expire;
  logic        kick;
  logic        wr;
  logic        rd;
  logic        hit_a;
  logic        hit_b;
  logic        src_clr;
  logic        own_drive;
  logic [31:0] rdata_nxt;
  function automatic logic sel(input logic [11:0] a, input logic [11:0] ofs);
    sel = (a == ofs);
  endfunction
  assign wr   = psel & penable & pwrite;
  assign rd   = psel & ~pwrite & ~penable;
  assign kick = wr & sel(paddr, `OFS_WDT_KICK) & (pwdata == `KICK_KEY);
  assign src_clr = wr & sel(paddr, `OFS_SRC_CLR) & pwdata[0];
  // =======================================
  // supply monitor and comparator
  assign low_v = supply_level < trip_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cal_or_fail_out <= 1'b0;
    else
      cal_or_fail_out <= early_fail_in < `VREF_CODE;
  end

  // =======================================
  // manual reset filter; masked by the pin enable itself, so our own release reads clean
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      man_s1_r <= 1'b0;
      man_s2_r <= 1'b0;
    end
    else
    begin
      man_s1_r <= ~sys_rst_in & ~sys_rst_oe;
      man_s2_r <= man_s1_r;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      deb_cnt_r <= 16'h0000;
      man_req_r <= 1'b0;
    end
    else if (man_s2_r == man_req_r)
      deb_cnt_r <= 16'h0000;
    else if (deb_cnt_r == 16'(DEB_N - 1))
    begin
      deb_cnt_r <= 16'h0000;
      man_req_r <= man_s2_r;
    end
    else
      deb_cnt_r <= deb_cnt_r + 16'h0001;
  end
  // =======================================
  // watchdog
  assign wdt_expire = ctrl_r[`CTRL_WDT_EN] & (state_r == supervisor_pkg::ST_RUN)
                      & (wdt_cnt_r >= wdt_steps_r) & ~kick;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_cnt_r <= 32'h0000_0000;
      wdt_cnt_r  <= 5'h00;
    end
    else if (kick || !ctrl_r[`CTRL_WDT_EN] || state_r != supervisor_pkg::ST_RUN)
    begin
      step_cnt_r <= 32'h0000_0000;
      wdt_cnt_r  <= 5'h00;
    end
    else if (step_cnt_r == STEP_CYCLES - 1)
    begin
      step_cnt_r <= 32'h0000_0000;
      wdt_cnt_r  <= wdt_cnt_r + 5'h01;
    end
    else
      step_cnt_r <= step_cnt_r + 32'h0000_0001;
  end

  // =======================================
  // reset sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r    <= supervisor_pkg::ST_HOLD;
      hold_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      case (state_r)
        supervisor_pkg::ST_HOLD:
        begin
          hold_cnt_r <= 32'h0000_0000;
          if (!low_v && !man_req_r)
            state_r <= supervisor_pkg::ST_WAIT;
        end
        supervisor_pkg::ST_WAIT:
        begin
          if (low_v || man_req_r)
          begin
            state_r    <= supervisor_pkg::ST_HOLD;
            hold_cnt_r <= 32'h0000_0000;
          end
          else if (hold_cnt_r == HOLD_CYCLES - 1)
            state_r <= supervisor_pkg::ST_RUN;
          else
            hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
        end
        supervisor_pkg::ST_RUN:
        begin
          hold_cnt_r <= 32'h0000_0000;
          if (low_v || man_req_r)
            state_r <= supervisor_pkg::ST_HOLD;
          else if (wdt_expire)
            state_r <= supervisor_pkg::ST_WAIT;
        end
        default:
          state_r <= supervisor_pkg::ST_HOLD;
      endcase
    end
  end
  assign own_drive = (state_r != supervisor_pkg::ST_RUN);
  // pin: output low always, enable carries the assertion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_rst_out <= 1'b0;
      sys_rst_oe  <= 1'b1;
    end
    else
    begin
      sys_rst_out <= 1'b0;
      sys_rst_oe  <= own_drive;
    end
  end

  // =======================================
  // reset source flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      src_r <= supervisor_pkg::SRC_NONE;
    else if (state_r == supervisor_pkg::ST_RUN && low_v)
      src_r <= supervisor_pkg::SRC_LOWV;
    else if (wdt_expire)
      src_r <= supervisor_pkg::SRC_WDT;
    else if (state_r == supervisor_pkg::ST_RUN && man_req_r)
      src_r <= supervisor_pkg::SRC_MAN;
    else if (src_clr)
      src_r <= supervisor_pkg::SRC_NONE;
  end

  // =======================================
  // event counters
  edge_counter u_cnt_a (
    .pclk     (pclk),
    .presetn  (presetn),
    .event_in (event_in_a),
    .pol      (ctrl_r[`CTRL_POL_A]),
    .view     (view_a),
    .hit      (hit_a)
  );
  edge_counter u_cnt_b (
    .pclk     (pclk),
    .presetn  (presetn),
    .event_in (event_in_b),
    .pol      (ctrl_r[`CTRL_POL_B]),
    .view     (view_b),
    .hit      (hit_b)
  );

  // =======================================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r      <= `CTRL_RESET;
      trip_r      <= `TRIP_RESET;
      wdt_steps_r <= `WDT_RESET;
    end
    else if (wr)
    begin
      if (sel(paddr, `OFS_CTRL))
        ctrl_r <= pwdata[3:0] | {ctrl_r[`CTRL_SER_LOCK], 3'b000};
      if (sel(paddr, `OFS_TRIP))
        trip_r <= pwdata[7:0];
      if (sel(paddr, `OFS_WDT_TIME))
      begin
        if (pwdata[4:0] < `WDT_MIN_STEPS)
          wdt_steps_r <= `WDT_MIN_STEPS;
        else if (pwdata[4:0] > `WDT_MAX_STEPS)
          wdt_steps_r <= `WDT_MAX_STEPS;
        else
          wdt_steps_r <= pwdata[4:0];
      end
    end
  end
  // lock is sticky until device reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      serial_r <= 64'h0000_0000_0000_0000;
    else if (wr && !ctrl_r[`CTRL_SER_LOCK])
    begin
      if (sel(paddr, `OFS_SER_LO))
        serial_r[31:0] <= pwdata;
      if (sel(paddr, `OFS_SER_HI))
        serial_r[63:32] <= pwdata;
    end
  end
  // =======================================
  // interrupts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_v_d_r   <= 1'b0;
      fail_d_r    <= 1'b0;
      man_req_d_r <= 1'b0;
    end
    else
    begin
      low_v_d_r   <= low_v;
      fail_d_r    <= cal_or_fail_out;
      man_req_d_r <= man_req_r;
    end
  end
  assign ev = {hit_b, hit_a, cal_or_fail_out & ~fail_d_r, man_req_r & ~man_req_d_r,
               wdt_expire, low_v & ~low_v_d_r};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_r <= 6'h00;
      irq_en_r   <= 6'h00;
    end
    else
    begin
      if (wr && sel(paddr, `OFS_IRQ_CLR))
        irq_stat_r <= (irq_stat_r & ~pwdata[5:0]) | ev;
      else
        irq_stat_r <= irq_stat_r | ev;
      if (wr && sel(paddr, `OFS_IRQ_EN))
        irq_en_r <= pwdata[5:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_r & irq_en_r);
  end

  // =======================================
  // apb read path, data latched in setup, answered with zero wait
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL:     rdata_nxt = {28'h0, ctrl_r};
      `OFS_TRIP:     rdata_nxt = {24'h0, trip_r};
      `OFS_WDT_TIME: rdata_nxt = {27'h0, wdt_steps_r};
      `OFS_STATUS:   rdata_nxt = {26'h0, cal_or_fail_out, man_req_r, low_v, state_r};
      `OFS_SRC:      rdata_nxt = {30'h0, src_r};
      `OFS_CNT_A:    rdata_nxt = {16'h0, view_a.count};
      `OFS_CNT_B:    rdata_nxt = {16'h0, view_b.count};
      `OFS_SER_LO:   rdata_nxt = serial_r[31:0];
      `OFS_SER_HI:   rdata_nxt = serial_r[63:32];
      `OFS_IRQ_STAT: rdata_nxt = {26'h0, irq_stat_r};
      `OFS_IRQ_EN:   rdata_nxt = {26'h0, irq_en_r};
      default:       rdata_nxt = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `OFS_IRQ_EN || paddr[1:0] != 2'b00);
      if (rd)
        prdata <= rdata_nxt;
    end
  end
endmodule // companion_supervisor

// *** supervisor_consts.svh ***
// constants for the processor companion supervisor
`ifndef SUPERVISOR_CONSTS_SVH
`define SUPERVISOR_CONSTS_SVH
// =======================================
// register byte offsets
`define OFS_CTRL      12'h000
`define OFS_TRIP      12'h004
`define OFS_WDT_TIME  12'h008
`define OFS_WDT_KICK  12'h00c
`define OFS_STATUS    12'h010
`define OFS_SRC       12'h014
`define OFS_SRC_CLR   12'h018
`define OFS_CNT_A     12'h01c
`define OFS_CNT_B     12'h020
`define OFS_SER_LO    12'h024
`define OFS_SER_HI    12'h028
`define OFS_IRQ_STAT  12'h02c
`define OFS_IRQ_CLR   12'h030
`define OFS_IRQ_EN    12'h034
// =======================================
// control fields
`define CTRL_WDT_EN   0
`define CTRL_POL_A    1
`define CTRL_POL_B    2
`define CTRL_SER_LOCK 3
`define CTRL_RESET    4'h0
`define TRIP_RESET    8'h80
`define VREF_CODE     8'h4d
`define WDT_RESET     5'h0a
`define KICK_KEY      32'h0000_00a5
// =======================================
// timing
`define CLK_HZ        25000000
`define RST_HOLD_MS   100
`define WDT_STEP_MS   100
`define WDT_MIN_STEPS 5'd1
`define WDT_MAX_STEPS 5'd30
`define DEB_US        20
`define DEB_CYCLES    ((`DEB_US * (`CLK_HZ / 1000000)))
// =======================================
// interrupt bits
`define IRQ_LOWV      0
`define IRQ_WDT       1
`define IRQ_MAN       2
`define IRQ_FAIL      3
`define IRQ_CNT_A     4
`define IRQ_CNT_B     5
`endif

// *** supervisor_pkg.sv ***
// types for the processor companion supervisor
package supervisor_pkg;
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_RUN  = 3'b010,
    ST_WAIT = 3'b100
  } rst_state_t;
  typedef struct packed {
    logic [15:0] count;
    logic        pol;
  } cnt_view_t;
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_LOWV = 2'h1,
    SRC_WDT  = 2'h2,
    SRC_MAN  = 2'h3
  } rst_src_t;
endpackage

// *** edge_counter.sv ***
// one 16-bit edge counter with selectable polarity
`timescale 1ns/100ps
`include "supervisor_consts.svh"
module edge_counter (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    event_in,
  input  wire logic                    pol,
  output supervisor_pkg::cnt_view_t    view,
  output logic                         hit
);
  logic        s1_r;
  logic        s2_r;
  logic        s3_r;
  logic [15:0] count_r;
  logic        rise;
  logic        fall;
  logic        edge_hit;

  // =======================================
  // sync and edge detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= event_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign rise     = s2_r & ~s3_r;
  assign fall     = ~s2_r & s3_r;
  assign edge_hit = pol ? fall : rise;

  // =======================================
  // counter, wraps at 16 bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r <= 16'h0000;
    else if (edge_hit)
      count_r <= count_r + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hit <= 1'b0;
    else
      hit <= edge_hit;
  end

  assign view.count = count_r;
  assign view.pol   = pol;
endmodule // edge_counter

// *** reset_pin_model.sv ***
// board model of the shared reset pin and its push button
`timescale 1ns/100ps
module reset_pin_model (
  input  wire logic oe,
  input  wire logic drive,
  input  wire logic press,
  output logic      pin
);
  // ====
  // wired level
  // weak pull-up wins only when nobody pulls low
  assign pin = press ? 1'b0 : (oe ? drive : 1'b1);
endmodule // reset_pin_model

// *** supervisor_props.sv ***
// port assertions for the supervisor
`timescale 1ns/100ps
`include "supervisor_consts.svh"
module supervisor_props #(
  parameter int unsigned HOLD_CYCLES = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [7:0]  supply_level,
  input wire logic [7:0]  early_fail_in,
  input wire logic        event_in_a,
  input wire logic        event_in_b,
  input wire logic        sys_rst_in,
  input wire logic        sys_rst_out,
  input wire logic        sys_rst_oe,
  input wire logic        cal_or_fail_out,
  input wire logic        irq
);
  // ====
  // shadows of written registers
  logic [7:0]  trip_r;
  logic [5:0]  en_r;
  logic [31:0] hi_cnt_r;
  logic        wr_w;
  logic        low_w;
  assign wr_w  = psel && penable && pready && pwrite && !pslverr;
  assign low_w = early_fail_in < `VREF_CODE;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) trip_r <= `TRIP_RESET;
    else if (wr_w && paddr == `OFS_TRIP) trip_r <= pwdata[7:0];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) en_r <= 6'h00;
    else if (wr_w && paddr == `OFS_IRQ_EN) en_r <= pwdata[5:0];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) hi_cnt_r <= 32'h0;
    else hi_cnt_r <= sys_rst_oe ? hi_cnt_r + 32'h1 : 32'h0;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    psel && penable && pready;
  endsequence
  // ====
  // assertions
  lowv_rst_a: assert property (supply_level < trip_r |-> ##[0:3] sys_rst_oe)
    else $error("low supply without reset");
  hold_len_a: assert property ($fell(sys_rst_oe) |-> hi_cnt_r >= HOLD_CYCLES)
    else $error("reset released too early");
  drain_low_a: assert property (sys_rst_out == 1'b0)
    else $error("reset pin driven high");
  fail_cmp_a: assert property ($past(presetn) |-> cal_or_fail_out == $past(low_w))
    else $error("fail output wrong");
  access_ready_a: assert property (setup_s |=> answer_s)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  bad_addr_a: assert property (pready && (paddr > `OFS_IRQ_EN || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("bad address not refused");
  irq_mask_a: assert property (en_r == 6'h00 && $past(en_r) == 6'h00 |-> !irq)
    else $error("masked interrupt raised");
endmodule // supervisor_props
bind companion_supervisor supervisor_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .supply_level(supply_level), .early_fail_in(early_fail_in), .event_in_a(event_in_a),
  .event_in_b(event_in_b), .sys_rst_in(sys_rst_in), .sys_rst_out(sys_rst_out),
  .sys_rst_oe(sys_rst_oe), .cal_or_fail_out(cal_or_fail_out), .irq(irq));

// *** companion_supervisor_tb.sv ***
// self-checking bench for the supervisor
`timescale 1ns/100ps
`include "supervisor_consts.svh"
module companion_supervisor_tb;
  localparam int H = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  supply_level, early_fail_in;
  logic        event_in_a, event_in_b, sys_rst_in, sys_rst_out, sys_rst_oe, cal_or_fail_out, press;
  logic [32:0] expq[$];
  int          err_total, comparisons, cyc, n, seed;
  companion_supervisor #(.HOLD_CYCLES(H), .STEP_CYCLES(10)) u_companion_supervisor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .supply_level(supply_level), .early_fail_in(early_fail_in), .event_in_a(event_in_a),
    .event_in_b(event_in_b), .sys_rst_in(sys_rst_in), .sys_rst_out(sys_rst_out),
    .sys_rst_oe(sys_rst_oe), .cal_or_fail_out(cal_or_fail_out), .irq(irq));
  reset_pin_model u_reset_pin_model (.oe(sys_rst_oe), .drive(sys_rst_out), .press(press), .pin(sys_rst_in));
  // ====
  // shared tasks
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wt(input logic v, input int lim);
    for (int i = 0; i < lim && sys_rst_oe !== v; i++) @(posedge pclk);
    chk({32'h0, sys_rst_oe}, {32'h0, v});
  endtask
  // stretch is at least H-4 cycles and ends within a few more
  task automatic hold_chk;
    repeat (H - 4) @(posedge pclk);
    chk({32'h0, sys_rst_oe}, 33'h1);
    wt(1'b0, 12);
  endtask
  task automatic print_verdict;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ====
  // clock, monitor, timeout
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, expq.pop_front());
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      print_verdict;
    end
  end
  // ====
  // scenarios
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    supply_level = 8'hff; early_fail_in = 8'hff; event_in_a = 1'b0; event_in_b = 1'b0; press = 1'b0;
    seed = $urandom(32'h7dcf750b);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    hold_chk;
    rd(`OFS_TRIP, 33'h80);
    rd(`OFS_WDT_TIME, 33'h0a);
    apb(1'b1, `OFS_IRQ_EN, 32'h1);
    supply_level <= 8'h7f;
    wt(1'b1, 4);
    chk({32'h0, sys_rst_in}, 33'h0);
    chk({32'h0, irq}, 33'h1);
    supply_level <= 8'h80;
    hold_chk;
    rd(`OFS_SRC, 33'h1);
    apb(1'b1, `OFS_SRC_CLR, 32'h1);
    apb(1'b1, `OFS_IRQ_CLR, 32'h1);
    rd(`OFS_SRC, 33'h0);
    chk({32'h0, irq}, 33'h0);
    apb(1'b1, `OFS_TRIP, 32'h40);
    supply_level <= 8'h40 + 8'($urandom_range(191, 0));
    repeat (5) @(posedge pclk);
    chk({32'h0, sys_rst_oe}, 33'h0);
    apb(1'b1, `OFS_WDT_TIME, 32'h0);
    rd(`OFS_WDT_TIME, 33'h1);
    apb(1'b1, `OFS_WDT_TIME, 32'h1f);
    rd(`OFS_WDT_TIME, 33'h1e);
    apb(1'b1, `OFS_WDT_TIME, 32'h1);
    apb(1'b1, `OFS_CTRL, 32'h1);
    repeat (5)
    begin
      repeat (5) @(posedge pclk);
      apb(1'b1, `OFS_WDT_KICK, `KICK_KEY);
    end
    chk({32'h0, sys_rst_oe}, 33'h0);
    apb(1'b1, `OFS_WDT_KICK, 32'ha4);
    wt(1'b1, 20);
    apb(1'b1, `OFS_CTRL, 32'h0);
    hold_chk;
    chk({32'h0, irq}, 33'h0);
    apb(1'b1, `OFS_IRQ_EN, 32'h2);
    repeat (3) @(posedge pclk);
    chk({32'h0, irq}, 33'h1);
    apb(1'b1, `OFS_IRQ_EN, 32'h0);
    rd(`OFS_SRC, 33'h2);
    apb(1'b1, `OFS_CTRL, 32'h4);
    n = $urandom_range(9, 3);
    repeat (n)
    begin
      event_in_a <= 1'b1; event_in_b <= 1'b1;
      repeat (4) @(posedge pclk);
      event_in_a <= 1'b0; event_in_b <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    // one extra rise tells the two polarities apart
    event_in_a <= 1'b1;
    event_in_b <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`OFS_CNT_A, 33'(n + 1));
    rd(`OFS_CNT_B, 33'(n));
    r = $urandom;
    apb(1'b1, `OFS_SER_LO, r);
    apb(1'b1, `OFS_SER_HI, ~r);
    apb(1'b1, `OFS_CTRL, 32'h8);
    apb(1'b1, `OFS_SER_LO, 32'h0);
    rd(`OFS_SER_LO, {1'b0, r});
    rd(`OFS_SER_HI, {1'b0, ~r});
    rd(12'h038, 33'h1_0000_0000);
    rd(12'h006, 33'h1_0000_0000);
    early_fail_in <= 8'h4c;
    repeat (3) @(posedge pclk);
    chk({32'h0, cal_or_fail_out}, 33'h1);
    early_fail_in <= 8'h4d;
    repeat (3) @(posedge pclk);
    chk({32'h0, cal_or_fail_out}, 33'h0);
    press <= 1'b1;
    repeat (100) @(posedge pclk);
    chk({32'h0, sys_rst_oe}, 33'h0);
    wt(1'b1, 520);
    press <= 1'b0;
    // release is debounced too, so the request lingers one filter period
    repeat (`DEB_CYCLES) @(posedge pclk);
    hold_chk;
    rd(`OFS_SRC, 33'h3);
    repeat (3) @(posedge pclk);
    print_verdict;
  end
endmodule // companion_supervisor_tb
